/* core_model.sv */
// processor core model: takes requests and returns from service
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic stall,
  input wire logic finish,
  output logic irq_ack,
  output logic return_from_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle ack while a request stands, held off by stall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'h0;
      return_from_irq <= 1'h0;
    end else begin
      irq_ack <= irq_req && !irq_ack && !stall;
      return_from_irq <= finish && !return_from_irq;
    end
  end
endmodule // core_model
`default_nettype wire

/* interrupt_priority_controller_tb.sv */
// testbench of the interrupt priority controller
`default_nettype none
module interrupt_priority_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, tdis = 1'h0, stall = 1'h1, finish = 1'h0;
  logic [3:0] addr = 4'h0, trap = 4'h0, lvl;
  logic [15:0] wdata = 16'h0, rdata;
  logic [11:0] flag = 12'h0, en = 12'h0;
  logic [2:0] sr = 3'h0;
  logic ack, ret, req, busy;
  logic [6:0] vec;
  logic [15:0] rst_val [4] = '{16'h4440, 16'h4044, 16'h4444, 16'h0044};
  logic [15:0] ones [4] = '{16'h7770, 16'h7077, 16'h7777, 16'h0077};
  int mismatches = 0, checks = 0;
  always #20 clk = ~clk;
  irq_prio_ctrl dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_flag(flag), .src_enable(en), .trap_level(trap), .cpu_level_sr(sr),
    .timed_irq_disable(tdis), .irq_ack(ack), .return_from_irq(ret), .irq_req(req),
    .irq_vector(vec), .cpu_level_now(lvl), .in_service(busy));
  core_model core (.clk(clk), .rst(rst), .irq_req(req), .stall(stall), .finish(finish),
    .irq_ack(ack), .return_from_irq(ret));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rd_chk(4'(i), rst_val[i]);
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'(i), 16'hFFFF);
      rd_chk(4'(i), ones[i]);
    end
    wr_reg(4'hF, 16'hFFFF);
    rd_chk(4'hF, 16'h0000);
  endtask
  task automatic t_arb;
    en <= 12'hFFF;
    flag <= 12'h028;
    tdis <= 1'h1;
    @(posedge clk);
    #1 chk(16'(req), 16'h1);
    chk(16'(vec), 16'h0023);
    sr <= 3'h7;
    wr_reg(4'h4, 16'h2000);
    chk(16'(req), 16'h0);
    rd_chk(4'h4, 16'hA01B);
    trap <= 4'hA;
    @(posedge clk);
    #1 chk(16'(req), 16'h1);
    trap <= 4'h0;
    sr <= 3'h0;
    tdis <= 1'h0;
    stall <= 1'h0;
    for (int i = 0; i < 10 && busy !== 1'h1; i++) @(posedge clk);
    #1 chk(16'(lvl), 16'h7);
    stall <= 1'h1;
    finish <= 1'h1;
    @(posedge clk);
    finish <= 1'h0;
    @(posedge clk);
    #1 chk(16'(lvl), 16'h0);
    chk(16'(req), 16'h1);
    wr_reg(4'h4, 16'h0000);
    rd_chk(4'h4, 16'h001B);
  endtask
  task automatic t_nest;
    wr_reg(4'h5, 16'h8000);
    rd_chk(4'h5, 16'h8000);
    wr_reg(4'h1, 16'h3003);
    tdis <= 1'h1;
    @(posedge clk);
    #1 chk(16'(req), 16'h0);
    tdis <= 1'h0;
    stall <= 1'h0;
    for (int i = 0; i < 10 && busy !== 1'h1; i++) @(posedge clk);
    #1 chk(16'(lvl), 16'h3);
    chk(16'(busy), 16'h1);
    stall <= 1'h1;
    flag <= 12'h029;
    @(posedge clk);
    #1 chk(16'(req), 16'h0);
    finish <= 1'h1;
    @(posedge clk);
    finish <= 1'h0;
    @(posedge clk);
    #1 chk(16'(busy), 16'h0);
    chk(16'(req), 16'h1);
    chk(16'(vec), 16'h0020);
  endtask
  task automatic close_out;
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_arb();
    t_nest();
    close_out();
  end
endmodule // interrupt_priority_controller_tb
`default_nettype wire

/* irq_prio_ctrl.sv */
// interrupt priority controller: priority fields, arbitration, status
//
// Chosen here: the register offsets and the plain strobed port.
`default_nettype none
module irq_prio_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [11:0] src_flag,
  input wire logic [11:0] src_enable,
  input wire logic [3:0] trap_level,
  input wire logic [2:0] cpu_level_sr,
  input wire logic timed_irq_disable,
  input wire logic irq_ack,
  input wire logic return_from_irq,
  output logic irq_req,
  output logic [6:0] irq_vector,
  output logic [3:0] cpu_level_now,
  output logic in_service
);
  localparam int N = irq_prio_pkg::NSRC;

  typedef struct packed {
    logic [N-1:0][2:0] prio;
    logic capture_sel;
    logic nesting_off;
    logic [3:0] level;
    logic [3:0] saved_level;
    logic [6:0] last_vec;
    logic [15:0] rdata;
    logic busy;
  } state_t;

  state_t s_q, s_d;

  // ==========================================================
  // arbitration
  logic [2:0] best_prio;
  logic [6:0] best_vec;
  logic any_req;
  logic user_ok;
  logic trap_ok;
  logic unacked;
  logic [3:0] eff_level;

  always_comb begin
    best_prio = 3'h0;
    best_vec = 7'h00;
    any_req = 1'b0;
    for (int i = 0; i < N; i++) begin
      // request only when enabled, flagged, nonzero
      if (src_enable[i] && src_flag[i] && s_q.prio[i] != 3'h0) begin
        if (!any_req || s_q.prio[i] > best_prio ||
            (s_q.prio[i] == best_prio && irq_prio_pkg::SRC_VECTOR[i] < best_vec)) begin
          best_prio = s_q.prio[i];
          best_vec = irq_prio_pkg::SRC_VECTOR[i];
        end
        any_req = 1'b1;
      end
    end
    eff_level = (s_q.level > {1'b0, cpu_level_sr}) ? s_q.level : {1'b0, cpu_level_sr};
    user_ok = any_req && ({1'b0, best_prio} > eff_level)
      && !(timed_irq_disable && best_prio != 3'h7)
      && !(s_q.nesting_off && s_q.busy);
    trap_ok = trap_level[3] && (trap_level > s_q.level || !s_q.busy);
    unacked = any_req && !user_ok && !trap_ok;
  end

  assign irq_req = user_ok || trap_ok;
  assign irq_vector = trap_ok ? irq_prio_pkg::TRAP_VECTOR_BASE[6:0] : best_vec;
  assign cpu_level_now = s_q.level;
  assign in_service = s_q.busy;
  assign rdata = s_q.rdata;

  // ==========================================================
  // register file and service tracking
  always_comb begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    if (wr) begin
      for (int i = 0; i < N; i++) begin
        if (addr == 4'(irq_prio_pkg::FIELD_REG[i]))
          s_d.prio[i] = wdata[irq_prio_pkg::FIELD_POS[i] +: 3];
      end
      if (addr == irq_prio_pkg::ADDR_STATUS)
        s_d.capture_sel = wdata[irq_prio_pkg::BIT_CAPTURE_SEL];
      if (addr == irq_prio_pkg::ADDR_CONTROL)
        s_d.nesting_off = wdata[irq_prio_pkg::BIT_NESTING_OFF];
    end
    if (rd) begin
      for (int i = 0; i < N; i++) begin
        if (addr == 4'(irq_prio_pkg::FIELD_REG[i]))
          s_d.rdata[irq_prio_pkg::FIELD_POS[i] +: 3] = s_q.prio[i];
      end
      if (addr == irq_prio_pkg::ADDR_STATUS) begin
        s_d.rdata[irq_prio_pkg::BIT_UNACKED] = unacked;
        s_d.rdata[irq_prio_pkg::BIT_CAPTURE_SEL] = s_q.capture_sel;
        s_d.rdata[11:8] = s_q.level;
        s_d.rdata[6:0] = s_q.capture_sel ? best_vec - irq_prio_pkg::VECTOR_BASE
                                         : s_q.last_vec - irq_prio_pkg::VECTOR_BASE;
      end
      if (addr == irq_prio_pkg::ADDR_CONTROL)
        s_d.rdata[irq_prio_pkg::BIT_NESTING_OFF] = s_q.nesting_off;
    end
    if (irq_ack && irq_req) begin
      s_d.saved_level = s_q.level;
      s_d.level = trap_ok ? trap_level : {1'b0, best_prio};
      s_d.last_vec = irq_vector;
      s_d.busy = 1'b1;
    end else if (return_from_irq) begin
      s_d.level = s_q.saved_level;
      s_d.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.prio <= {N{irq_prio_pkg::PRIO_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // checks
  reset_prio_a: assert property (@(posedge clk) $rose(!rst) |-> s_q.prio[0] == 3'h4)
    else $error("priority not at level four after reset");
  zero_prio_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.prio == '0 && !trap_level[3]) |-> !irq_req)
    else $error("request from disabled source");
  mask_seven_a: assert property (@(posedge clk) disable iff (rst)
    (cpu_level_sr == 3'h7 && !trap_level[3]) |-> !irq_req)
    else $error("user request above level seven mask");
  trap_pass_a: assert property (@(posedge clk) disable iff (rst)
    (trap_level[3] && !s_q.busy) |-> irq_req)
    else $error("trap masked");
  timed_off_a: assert property (@(posedge clk) disable iff (rst)
    (timed_irq_disable && irq_req && !trap_level[3]) |-> best_prio == 3'h7)
    else $error("timed disable let low priority pass");
  nest_off_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.nesting_off && s_q.busy && !trap_level[3]) |-> !irq_req)
    else $error("nesting while disabled");
  restore_lvl_a: assert property (@(posedge clk) disable iff (rst)
    (return_from_irq && !(irq_ack && irq_req)) |=> s_q.level == $past(s_q.saved_level))
    else $error("level not restored");
  ilr_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == 4'h4) |=> rdata[11:8] == $past(s_q.level) && rdata[7] == 1'b0)
    else $error("status level field wrong");
  unacked_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == 4'h4) |=> rdata[15] == $past(unacked))
    else $error("unacked bit wrong");
  unimpl_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == 4'h3) |=> rdata[15:7] == 9'h000 && rdata[3] == 1'b0)
    else $error("unimplemented bits nonzero");
endmodule // irq_prio_ctrl
`default_nettype wire

/* irq_prio_pkg.sv */
// constants, register map and field layout of the interrupt priority controller
// What this block does
// - three-bit priority, zero disables, seven highest
// - every priority field resets to level four
// - unimplemented bits ignore writes, read zero
// - uart c: tx 14-12, rx 10-8, err 6-4
// - uart d err, i2c master, i2c slave fields
// - spi event, spi fault, uart d tx, rx
// - capture nine 6-4, compare nine 2-0
// - bit 15 flags a user request held off by level, timed disable or nesting off, with no trap passing
// - bit 13 selects pending or last acknowledged vector
// - cpu level shown in bits 11-8
// - vector field holds vector number minus eight
// - nesting off blocks user-interrupt preemption during service; traps still preempt
// - request stays while flag and enable set
// - return restores saved level and clears in-service
// - traps re-enter until trap flag cleared
// - level seven masks all user interrupts
// - traps at 8-15 are masked only while in service at an equal or higher level
// - timed disable blocks 1-6, not 7
// - request needs enable, flag, nonzero priority
`default_nettype none
package irq_prio_pkg;
  localparam int NSRC = 12;
  localparam logic [3:0] ADDR_UART_C = 4'h0;
  localparam logic [3:0] ADDR_UART_D_I2C = 4'h1;
  localparam logic [3:0] ADDR_SPI_UART_D = 4'h2;
  localparam logic [3:0] ADDR_CAP_CMP = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h5;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [3:0] LEVEL_USER_MAX = 4'h7;
  localparam logic [6:0] VECTOR_BASE = 7'h08;
  localparam int BIT_UNACKED = 15;
  localparam int BIT_CAPTURE_SEL = 13;
  localparam int BIT_NESTING_OFF = 15;
  // bit offset of each source's field and its register index
  localparam int FIELD_POS [NSRC] = '{12, 8, 4, 12, 4, 0, 12, 8, 4, 0, 4, 0};
  localparam int FIELD_REG [NSRC] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3};
  // vector id of each source, ascending in source order within the block
  localparam logic [6:0] SRC_VECTOR [NSRC] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24,
    7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h2B};
  localparam logic [15:0] TRAP_VECTOR_BASE = 16'h0000;
endpackage
`default_nettype wire
